/* mpc_debounce.sv */
`timescale 1ns/1ps
module mpc_debounce
   import mpc_pkg::*;
#(
   parameter int CNT_W = MPC_DBC_CNT_W
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic tick,
   input wire logic [CNT_W-1:0] limit,
   // Data
   input wire logic din,
   output logic dout
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic dout_q;
   logic dout_d;
   wire differs = din != dout_q;
   wire bypass = limit == '0;

   // Counter restarts whenever input agrees with output again
   always_comb begin
      cnt_d = cnt_q;
      dout_d = dout_q;
      if (bypass) begin
         dout_d = din;
         cnt_d = '0;
      end else if (!differs) begin
         cnt_d = '0;
      end else if (tick) begin
         if (cnt_q + 1'b1 >= limit) begin
            dout_d = din;
            cnt_d = '0;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
         dout_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         dout_q <= dout_d;
      end
   end

   assign dout = dout_q;

endmodule : mpc_debounce

/* mpc_pad_model.sv */
`timescale 1ns/1ps
module mpc_pad_model
   import mpc_pkg::*;
#(
   parameter int NUM_PINS = MPC_NUM_PINS
) (
   // Design side
   input wire logic [NUM_PINS-1:0] pad_out,
   input wire logic [NUM_PINS-1:0] pad_oe,
   input wire logic [NUM_PINS-1:0] pad_pullup_en,
   // Level that the outside world puts on an undriven pin
   input wire logic [NUM_PINS-1:0] ext_level,
   output logic [NUM_PINS-1:0] pad_in
);
   // A driven pin reads back its own level; the pull-up wins over the outside world
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & (pad_pullup_en | ext_level));
endmodule : mpc_pad_model

/* mpc_pkg.sv */
package mpc_pkg;

   // Pin count and register map (printed offsets are word indices)
   localparam int MPC_NUM_PINS = 14;
   localparam int MPC_ADDR_W = 18;
   localparam logic [15:0] MPC_CFG_BASE_IDX = 16'hf510;
   localparam logic [15:0] MPC_WR_BASE_IDX = 16'hf520;
   localparam logic [15:0] MPC_RD_BASE_IDX = 16'hf530;
   localparam logic [15:0] MPC_IDX_STEP = 16'h0001;

   // Configuration register fields
   localparam int MPC_EN_BIT = 0;
   localparam int MPC_FUNC_LSB = 1;
   localparam int MPC_FUNC_MSB = 3;
   localparam int MPC_DBC_LSB = 4;
   localparam int MPC_DBC_MSB = 7;
   localparam int MPC_SS_LSB = 8;
   localparam int MPC_SS_MSB = 10;
   localparam logic [15:0] MPC_CFG_RESET = 16'h0000;
   localparam logic [15:0] MPC_VAL_RESET = 16'h0000;
   localparam logic [15:0] MPC_CFG_MASK = 16'h07ff;

   // AXI responses
   localparam logic [1:0] MPC_RESP_OKAY = 2'h0;
   localparam logic [1:0] MPC_RESP_SLVERR = 2'h2;

   // Debounce time base: one tick per 0.1 ms
   localparam int MPC_CLK_PERIOD_PS = 25000;
   localparam int MPC_TICK_US = 100;
   localparam int MPC_TICK_CYCLES = (MPC_TICK_US * 1000000) / MPC_CLK_PERIOD_PS;
   localparam int MPC_DBC_CNT_W = 9;

   // Debounce durations in microseconds
   localparam int MPC_DBC_US_1 = 300;
   localparam int MPC_DBC_US_2 = 600;
   localparam int MPC_DBC_US_3 = 900;
   localparam int MPC_DBC_US_4 = 5000;
   localparam int MPC_DBC_US_5 = 10000;
   localparam int MPC_DBC_US_6 = 20000;
   localparam int MPC_DBC_US_7 = 40000;

   typedef enum logic [2:0] {
      MPC_FN_GP_IN = 3'h0,
      MPC_FN_REG_IN = 3'h1,
      MPC_FN_OUT_PU = 3'h2,
      MPC_FN_OUT_NOPU = 3'h3,
      MPC_FN_PDM_IN = 3'h4,
      MPC_FN_PANIC = 3'h5,
      MPC_FN_SS_OUT = 3'h6,
      MPC_FN_RSVD = 3'h7
   } mpc_func_e;

   typedef struct packed {
      logic [2:0] ss_sel;
      logic [3:0] dbc_code;
      mpc_func_e func;
      logic alt_en;
   } mpc_cfg_s;

   function automatic logic [MPC_DBC_CNT_W-1:0] mpc_dbc_ticks(input logic [3:0] code);
      int us;
      case (code)
         4'h1: us = MPC_DBC_US_1;
         4'h2: us = MPC_DBC_US_2;
         4'h3: us = MPC_DBC_US_3;
         4'h4: us = MPC_DBC_US_4;
         4'h5: us = MPC_DBC_US_5;
         4'h6: us = MPC_DBC_US_6;
         4'h7: us = MPC_DBC_US_7;
         default: us = 0;
      endcase
      return MPC_DBC_CNT_W'(us / MPC_TICK_US);
   endfunction : mpc_dbc_ticks

endpackage : mpc_pkg

/* mpc_top.sv */
`timescale 1ns/1ps
// Operation
// RQ1: Debounce applies only in general-purpose input mode
// RQ2: Debounce codes map to 0.3 to 40 ms
// RQ3: Function field acts only when enable set
// RQ4: Codes 000 input, 010/011 output pull-up options
// RQ5: Code 001 core level overridable by register
// RQ6: Code 100 PDM input, 101 panic flag out
// RQ7: Code 110 drives SPI slave select output
// RQ8: Enable zero keeps primary function, ignores registers
// RQ9: Config bit 0 selects multipurpose operation
// RQ10: Write register bit 0 sets core level
// RQ11: Write registers at indices F520 to F52D
// RQ12: Read registers F530 to F53D return level
// RQ13: Field 10:8 picks slave select channel 1-6
// RQ14: Level passes after stable for selected time
// RQ15: All configuration zero after reset
module mpc_top
   import mpc_pkg::*;
#(
   parameter int NUM_PINS = MPC_NUM_PINS,
   parameter int ADDR_W = MPC_ADDR_W,
   parameter int SS_CH = 7
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Pads
   input wire logic [NUM_PINS-1:0] pad_in,
   output logic [NUM_PINS-1:0] pad_out,
   output logic [NUM_PINS-1:0] pad_oe,
   output logic [NUM_PINS-1:0] pad_pullup_en,
   // Primary audio clock and control functions
   input wire logic [NUM_PINS-1:0] prim_out,
   input wire logic [NUM_PINS-1:0] prim_oe,
   output logic [NUM_PINS-1:0] prim_in,
   // DSP core side
   input wire logic [NUM_PINS-1:0] core_out_level,
   output logic [NUM_PINS-1:0] core_pin_level,
   // Other blocks
   output logic [NUM_PINS-1:0] pdm_data,
   input wire logic panic_flag,
   input wire logic [SS_CH-1:0] spi_ss_n
);

   localparam int TICK_W = $clog2(MPC_TICK_CYCLES);
   localparam int IDX_W = ADDR_W - 2;

   // Register state
   mpc_cfg_s cfg_q [NUM_PINS];
   logic [NUM_PINS-1:0] forced_pin_level_q;
   logic [NUM_PINS-1:0] force_active_q;
   logic [NUM_PINS-1:0] prev_pin_q;

   // Bus state
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic aw_hold_q;
   logic w_hold_q;
   logic [IDX_W-1:0] aw_idx_q;
   logic [15:0] w_data_q;
   logic [1:0] w_strb_q;

   // Output registers
   logic [NUM_PINS-1:0] pad_out_q;
   logic [NUM_PINS-1:0] pad_oe_q;
   logic [NUM_PINS-1:0] pad_pu_q;
   logic [NUM_PINS-1:0] prim_in_q;
   logic [NUM_PINS-1:0] core_level_q;
   logic [NUM_PINS-1:0] pdm_q;
   logic [NUM_PINS-1:0] read_level_q;

   // Debounce time base
   logic [TICK_W-1:0] tick_cnt_q;
   logic tick_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == TICK_W'(MPC_TICK_CYCLES - 1)) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b1; // [RQ14]
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   // Write channel: address and data may arrive in either order
   wire aw_take = awvalid & awready_q;
   wire w_take = wvalid & wready_q;
   wire do_write = aw_hold_q & w_hold_q & ~bvalid_q;
   wire b_done = bvalid_q & bready;
   wire aw_hold_d = (aw_hold_q | aw_take) & ~do_write;
   wire w_hold_d = (w_hold_q | w_take) & ~do_write;
   wire bvalid_d = (bvalid_q & ~b_done) | do_write;

   // Decode of the held write index
   wire [IDX_W-1:0] wcfg_off = aw_idx_q - IDX_W'(MPC_CFG_BASE_IDX);
   wire [IDX_W-1:0] wval_off = aw_idx_q - IDX_W'(MPC_WR_BASE_IDX);
   wire [IDX_W-1:0] wrd_off = aw_idx_q - IDX_W'(MPC_RD_BASE_IDX);
   wire w_is_cfg = wcfg_off < IDX_W'(NUM_PINS);
   wire w_is_val = wval_off < IDX_W'(NUM_PINS); // [RQ11]
   wire w_is_rd = wrd_off < IDX_W'(NUM_PINS);
   wire w_mapped = w_is_cfg | w_is_val | w_is_rd;

   // Read channel decode
   wire ar_take = arvalid & arready_q;
   wire r_done = rvalid_q & rready;
   wire [IDX_W-1:0] ar_idx = araddr[ADDR_W-1:2];
   wire [IDX_W-1:0] rcfg_off = ar_idx - IDX_W'(MPC_CFG_BASE_IDX);
   wire [IDX_W-1:0] rval_off = ar_idx - IDX_W'(MPC_WR_BASE_IDX);
   wire [IDX_W-1:0] rrd_off = ar_idx - IDX_W'(MPC_RD_BASE_IDX);
   wire r_is_cfg = rcfg_off < IDX_W'(NUM_PINS);
   wire r_is_val = rval_off < IDX_W'(NUM_PINS);
   wire r_is_rd = rrd_off < IDX_W'(NUM_PINS); // [RQ12]
   wire r_mapped = r_is_cfg | r_is_val | r_is_rd;
   wire [3:0] rcfg_sel = rcfg_off[3:0];
   wire [3:0] rrd_sel = rrd_off[3:0];
   // Write-only value registers read back as zero
   wire [15:0] cfg_word = r_is_cfg ? 16'(cfg_q[rcfg_sel]) : 16'h0000;
   wire [15:0] rd_word = r_is_rd ? {15'h0000, read_level_q[rrd_sel]} : 16'h0000;
   wire [31:0] rdata_d = {16'h0000, cfg_word | rd_word};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= MPC_RESP_OKAY;
         aw_idx_q <= '0;
         w_data_q <= MPC_VAL_RESET;
         w_strb_q <= 2'h0;
      end else begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         awready_q <= ~aw_hold_d & ~bvalid_d;
         wready_q <= ~w_hold_d & ~bvalid_d;
         bvalid_q <= bvalid_d;
         if (do_write) begin
            bresp_q <= w_mapped ? MPC_RESP_OKAY : MPC_RESP_SLVERR;
         end
         if (aw_take) begin
            aw_idx_q <= awaddr[ADDR_W-1:2];
         end
         if (w_take) begin
            w_data_q <= wdata[15:0];
            w_strb_q <= wstrb[1:0];
         end
      end
   end

   // One read at a time; arready returns once the data is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= MPC_RESP_OKAY;
      end else if (ar_take) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rdata_d;
         rresp_q <= r_mapped ? MPC_RESP_OKAY : MPC_RESP_SLVERR;
      end else if (r_done) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
      end
   end

   // Byte-lane merge of the held write into a 16-bit register image
   wire [15:0] strb_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         logic deb_level;
         logic [15:0] cfg_old;
         logic [15:0] cfg_new;
         logic cfg_we;
         logic val_we;
         logic in_mode;
         logic [2:0] ss_ch;
         logic ss_level;
         mpc_cfg_s c;

         assign c = cfg_q[gi];
         assign cfg_old = 16'(cfg_q[gi]);
         assign cfg_new = ((cfg_old & ~strb_mask) | (w_data_q & strb_mask)) & MPC_CFG_MASK;
         assign cfg_we = do_write & w_is_cfg & (wcfg_off == IDX_W'(gi));
         // Only bit 0 carries a value; the upper bits are reserved
         // A value write to a pin left in its primary function is dropped
         assign val_we = do_write & w_is_val & (wval_off == IDX_W'(gi)) & // [RQ10]
                         w_strb_q[0] & c.alt_en; // [RQ8]
         assign in_mode = (c.func == MPC_FN_GP_IN) || (c.func == MPC_FN_REG_IN) ||
                          (c.func == MPC_FN_PDM_IN) || (c.func == MPC_FN_RSVD);
         assign ss_ch = c.ss_sel;
         // Channel 0 lives on its fixed pin; 0 and 7 leave this pin deselected
         assign ss_level = (ss_ch >= 3'h1 && ss_ch <= 3'h6) ? spi_ss_n[ss_ch] : 1'b1; // [RQ13]

         // Filter length is zero unless the pin is a plain input
         mpc_debounce #(
            .CNT_W(MPC_DBC_CNT_W)
         ) u_deb (
            .aclk(aclk),
            .aresetn(aresetn),
            .tick(tick_q),
            .limit((c.alt_en && c.func == MPC_FN_GP_IN) ?
                   mpc_dbc_ticks(c.dbc_code) : '0), // [RQ1] [RQ2]
            .din(pad_in[gi]),
            .dout(deb_level)
         );

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               cfg_q[gi] <= mpc_cfg_s'(MPC_CFG_RESET); // [RQ15]
               forced_pin_level_q[gi] <= 1'b0;
               force_active_q[gi] <= 1'b0;
               prev_pin_q[gi] <= 1'b0;
            end else begin
               if (cfg_we) begin
                  cfg_q[gi] <= mpc_cfg_s'(cfg_new);
               end
               prev_pin_q[gi] <= pad_in[gi];
               if (val_we) begin
                  forced_pin_level_q[gi] <= w_data_q[0];
               end
               // A register write overrides until the pin itself moves; write wins a tie
               if (val_we) begin
                  force_active_q[gi] <= 1'b1; // [RQ5]
               end else if (pad_in[gi] != prev_pin_q[gi]) begin
                  force_active_q[gi] <= 1'b0;
               end
            end
         end

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               pad_out_q[gi] <= 1'b0;
               pad_oe_q[gi] <= 1'b0;
               pad_pu_q[gi] <= 1'b0;
               prim_in_q[gi] <= 1'b0;
               core_level_q[gi] <= 1'b0;
               pdm_q[gi] <= 1'b0;
               read_level_q[gi] <= 1'b0;
            end else if (!c.alt_en) begin
               pad_out_q[gi] <= prim_out[gi]; // [RQ8] [RQ9]
               pad_oe_q[gi] <= prim_oe[gi];
               pad_pu_q[gi] <= 1'b0;
               prim_in_q[gi] <= pad_in[gi];
               core_level_q[gi] <= 1'b0;
               pdm_q[gi] <= 1'b0;
               read_level_q[gi] <= 1'b0;
            end else begin
               prim_in_q[gi] <= 1'b0;
               read_level_q[gi] <= in_mode ?
                  ((c.func == MPC_FN_GP_IN) ? deb_level : pad_in[gi]) : 1'b0; // [RQ12]
               pdm_q[gi] <= (c.func == MPC_FN_PDM_IN) ? pad_in[gi] : 1'b0;
               case (c.func) // [RQ3]
                  MPC_FN_GP_IN: begin
                     pad_out_q[gi] <= 1'b0;
                     pad_oe_q[gi] <= 1'b0;
                     pad_pu_q[gi] <= 1'b0;
                     core_level_q[gi] <= deb_level; // [RQ4] [RQ14]
                  end
                  MPC_FN_REG_IN: begin
                     pad_out_q[gi] <= 1'b0;
                     pad_oe_q[gi] <= 1'b0;
                     pad_pu_q[gi] <= 1'b0;
                     core_level_q[gi] <= force_active_q[gi] ?
                        forced_pin_level_q[gi] : pad_in[gi]; // [RQ5]
                  end
                  MPC_FN_OUT_PU: begin
                     pad_out_q[gi] <= core_out_level[gi];
                     pad_oe_q[gi] <= 1'b1;
                     pad_pu_q[gi] <= 1'b1; // [RQ4]
                     core_level_q[gi] <= 1'b0;
                  end
                  MPC_FN_OUT_NOPU: begin
                     pad_out_q[gi] <= core_out_level[gi];
                     pad_oe_q[gi] <= 1'b1;
                     pad_pu_q[gi] <= 1'b0; // [RQ4]
                     core_level_q[gi] <= 1'b0;
                  end
                  MPC_FN_PDM_IN: begin
                     pad_out_q[gi] <= 1'b0;
                     pad_oe_q[gi] <= 1'b0; // [RQ6]
                     pad_pu_q[gi] <= 1'b0;
                     core_level_q[gi] <= 1'b0;
                  end
                  MPC_FN_PANIC: begin
                     pad_out_q[gi] <= panic_flag; // [RQ6]
                     pad_oe_q[gi] <= 1'b1;
                     pad_pu_q[gi] <= 1'b0;
                     core_level_q[gi] <= 1'b0;
                  end
                  MPC_FN_SS_OUT: begin
                     pad_out_q[gi] <= ss_level; // [RQ7]
                     pad_oe_q[gi] <= 1'b1;
                     pad_pu_q[gi] <= 1'b0;
                     core_level_q[gi] <= 1'b0;
                  end
                  default: begin
                     // Reserved code keeps the pad released
                     pad_out_q[gi] <= 1'b0;
                     pad_oe_q[gi] <= 1'b0;
                     pad_pu_q[gi] <= 1'b0;
                     core_level_q[gi] <= pad_in[gi];
                  end
               endcase
            end
         end
      end
   endgenerate

   // Outputs
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign pad_out = pad_out_q;
   assign pad_oe = pad_oe_q;
   assign pad_pullup_en = pad_pu_q;
   assign prim_in = prim_in_q;
   assign core_pin_level = core_level_q;
   assign pdm_data = pdm_q;

endmodule : mpc_top

/* mpc_top_monitor.sv */
`timescale 1ns/1ps
module mpc_top_monitor
   import mpc_pkg::*;
#(
   parameter int NUM_PINS = MPC_NUM_PINS
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   // Pins
   input wire logic [NUM_PINS-1:0] pad_in,
   input wire logic [NUM_PINS-1:0] pad_oe,
   input wire logic [NUM_PINS-1:0] prim_in,
   input wire logic [NUM_PINS-1:0] pdm_data,
   input wire logic [NUM_PINS-1:0] core_pin_level
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_b_answer;
      !bvalid ##1 bvalid;
   endsequence
   AST_WR_LAT: assert property (s_wr_taken |=> s_b_answer)
      else $error("write response late or early");
   AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   AST_RD_LAT: assert property (arvalid && arready |=> rvalid)
      else $error("read data not one cycle after address");
   AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped or changed");
   AST_RD_UPPER: assert property (rvalid |-> rdata[31:11] == 21'h0)
      else $error("reserved read bits set");
   AST_PRIM_IN: assert property ((prim_in & ~$past(pad_in)) == '0)
      else $error("primary input not from pad");
   AST_PDM_IN: assert property ((pdm_data & ~$past(pad_in)) == '0)
      else $error("microphone data not from pad");
   AST_EXCL: assert property ((prim_in & (pdm_data | core_pin_level)) == '0)
      else $error("primary pin also routed to core or microphone");
   AST_RESET: assert property (disable iff (1'b0) !aresetn |=>
      pad_oe == '0 && core_pin_level == '0 && awready && !bvalid && !rvalid)
      else $error("outputs not cleared by reset");
endmodule : mpc_top_monitor

bind mpc_top mpc_top_monitor #(.NUM_PINS(NUM_PINS)) i_mon (.aclk, .aresetn, .awvalid,
   .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid,
   .rready, .rdata, .rresp, .pad_in, .pad_oe, .prim_in, .pdm_data, .core_pin_level);

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import mpc_pkg::*;
   localparam int NP = MPC_NUM_PINS;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic panic_flag = 1'b0;
   logic [MPC_ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic [NP-1:0] prim_out = '0, prim_oe = '0, core_out_level = '0, ext_level = '0;
   logic [6:0] spi_ss_n = 7'h7f;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rd;
   logic [NP-1:0] pad_in, pad_out, pad_oe, pad_pullup_en, prim_in, core_pin_level, pdm_data;
   logic [4:0] exp_v;
   logic exp_o;
   mpc_cfg_s cfg;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int n;

   always #12.5 aclk = ~aclk;

   mpc_top i_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
      .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
      .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .pad_in, .pad_out, .pad_oe,
      .pad_pullup_en, .prim_out, .prim_oe, .prim_in, .core_out_level, .core_pin_level,
      .pdm_data, .panic_flag, .spi_ss_n);
   mpc_pad_model i_pads (.pad_out, .pad_oe, .pad_pullup_en, .ext_level, .pad_in);

   task automatic tally_and_finish();
      $display("mismatches %0d, comparisons %0d", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   // Hang guard: the whole sequence needs roughly 12000 cycles
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         $display("unexpected at %0t: timeout", $time);
         tally_and_finish();
      end
   end

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: data %h, want %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: response %h, want %h", $time, got, exp);
      end
   endtask : cmp_resp

   task automatic cmp_pins(input logic [NP-1:0] got, input logic [NP-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: pins %h, want %h", $time, got, exp);
      end
   endtask : cmp_pins

   task automatic settle(input int c);
      repeat (c) @(posedge aclk);
      @(negedge aclk);
   endtask : settle

   task automatic wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= {idx, 2'h0};
      wdata <= d;
      wstrb <= 4'hf;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid === 1'b1));
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= {idx, 2'h0};
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid === 1'b1));
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rdr

   task automatic set_cfg(input int p, input mpc_cfg_s c);
      wr(MPC_CFG_BASE_IDX + 16'(p), {21'h0, c}, rs);
      settle(4);
   endtask : set_cfg

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      settle(1);
      for (int p = 0; p < NP; p += 13) begin
         rdr(MPC_CFG_BASE_IDX + 16'(p), rd, rs);
         cmp_word(rd, 32'h0);
         cmp_resp(rs, MPC_RESP_OKAY);
         rdr(MPC_RD_BASE_IDX + 16'(p), rd, rs);
         cmp_word(rd, 32'h0);
      end
      rdr(16'hf540, rd, rs);
      cmp_resp(rs, MPC_RESP_SLVERR);
      wr(16'hf540, 32'h1, rs);
      cmp_resp(rs, MPC_RESP_SLVERR);
      rdr(MPC_WR_BASE_IDX, rd, rs);
      cmp_word(rd, 32'h0);
      wr(MPC_RD_BASE_IDX + 16'h000d, 32'h1, rs);
      cmp_resp(rs, MPC_RESP_OKAY);
      wr(MPC_CFG_BASE_IDX + 16'h0005, 32'hffffffff, rs);
      rdr(MPC_CFG_BASE_IDX + 16'h0005, rd, rs);
      cmp_word(rd, 32'h000007ff);
      wr(MPC_CFG_BASE_IDX + 16'h0005, 32'h0, rs);
      // Function code without the enable bit must leave the pin primary
      ext_level <= 14'h2a5c;
      prim_out <= 14'h1333;
      prim_oe <= 14'h0f0f;
      cfg = '0;
      cfg.func = MPC_FN_OUT_PU;
      set_cfg(13, cfg);
      wr(MPC_WR_BASE_IDX + 16'h000d, 32'h0, rs);
      settle(3);
      cmp_pins(pad_oe, 14'h0f0f);
      cmp_pins(pad_out, 14'h1333);
      cmp_pins(pad_pullup_en, 14'h0);
      cmp_pins(core_pin_level, 14'h0);
      cmp_pins(prim_in, (14'h1333 & 14'h0f0f) | (14'h2a5c & ~14'h0f0f));
      // The value written while primary must not override the pin once enabled
      cfg.alt_en = 1'b1;
      cfg.func = MPC_FN_REG_IN;
      set_cfg(13, cfg);
      cmp_pins(core_pin_level & 14'h2000, 14'h2000);
      prim_oe <= '0;
      core_out_level <= 14'h0040;
      panic_flag <= 1'b1;
      spi_ss_n <= 7'h55;
      // Each function code except reserved 111 on pin 6, whose outside level is high
      for (int f = 0; f < 7; f++) begin
         cfg = '0;
         cfg.alt_en = 1'b1;
         cfg.func = mpc_func_e'(f);
         cfg.ss_sel = 3'h3;
         set_cfg(6, cfg);
         exp_o = (f == 5) ? panic_flag : (f == 6) ? spi_ss_n[3] : core_out_level[6];
         exp_v = (f inside {2, 3, 5, 6}) ? {1'b1, f == 2, exp_o, 2'h0} : {3'h0, f < 2, f == 4};
         cmp_word({27'h0, pad_oe[6], pad_pullup_en[6], pad_out[6] & pad_oe[6],
            core_pin_level[6], pdm_data[6]}, {27'h0, exp_v});
         if (f != 1) begin
            rdr(MPC_RD_BASE_IDX + 16'h0006, rd, rs);
            cmp_word(rd, {31'h0, f == 0 || f == 4});
         end else begin
            wr(MPC_WR_BASE_IDX + 16'h0006, 32'h0, rs);
            settle(3);
            cmp_pins(core_pin_level & 14'h0040, 14'h0);
            @(posedge aclk) ext_level[6] <= 1'b0;
            @(posedge aclk) ext_level[6] <= 1'b1;
            settle(4);
            cmp_pins(core_pin_level & 14'h0040, 14'h0040);
         end
      end
      // Slave select channel choice, including the two unused codes
      for (int ch = 0; ch < 8; ch++) begin
         cfg.func = MPC_FN_SS_OUT;
         cfg.ss_sel = 3'(ch);
         set_cfg(6, cfg);
         cmp_pins(pad_out & 14'h0040, {7'h0, (ch >= 1 && ch <= 6) ? spi_ss_n[ch] : 1'b1,
            6'h0});
      end
      // Shortest debounce: three ticks of 4000 cycles each
      cfg = '0;
      cfg.alt_en = 1'b1;
      cfg.dbc_code = 4'h1;
      set_cfg(6, cfg);
      @(posedge aclk) ext_level[6] <= 1'b0;
      settle(2 * MPC_TICK_CYCLES - 10);
      cmp_pins(core_pin_level & 14'h0040, 14'h0040);
      n = 0;
      while (core_pin_level[6] !== 1'b0 && n < MPC_TICK_CYCLES + 40) begin
         @(posedge aclk);
         n++;
      end
      settle(1);
      cmp_pins(core_pin_level & 14'h0040, 14'h0);
      // The longest setting must not delay a register-driven input
      cfg.func = MPC_FN_REG_IN;
      cfg.dbc_code = 4'h7;
      set_cfg(6, cfg);
      @(posedge aclk) ext_level[6] <= 1'b1;
      settle(4);
      cmp_pins(core_pin_level & 14'h0040, 14'h0040);
      // Reset in mid-run clears the configuration
      @(posedge aclk) aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      settle(1);
      cmp_pins(pad_oe, 14'h0);
      rdr(MPC_CFG_BASE_IDX + 16'h0006, rd, rs);
      cmp_word(rd, 32'h0);
      tally_and_finish();
   end
endmodule : tb_top
